/* File: hdl/sensor_control_reg_map.vh */
/*
  Constants for the calibrated temperature readout: register offsets,
  reset values, field positions and timing counts.
  Assumes a 100 MHz pclk and 32-bit APB data.
*/
`ifndef TSCRD_MAP_VH
`define TSCRD_MAP_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TS_OFS_CTRL     8'h00
`define TS_OFS_SUPPLY   8'h04
`define TS_OFS_VREF     8'h08
`define TS_OFS_CAL_LO   8'h0C
`define TS_OFS_CAL_MID  8'h10
`define TS_OFS_CAL_HI   8'h14
`define TS_OFS_STATUS   8'h18
`define TS_OFS_ROOM     8'h1C
`define TS_OFS_SLOPE    8'h20
`define TS_OFS_TEMP     8'h24
`define TS_OFS_HIGH     8'h28
// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define TS_RST_GAIN     2'b01
`define TS_RST_MV       16'h0CE4
`define TS_CAL_W        10
`define TS_GAIN_LO_RNG  2'b00
`define TS_GAIN_HI_RNG  2'b01
// ----------------------------------------
// Timing
// ----------------------------------------
`define TS_CLK_MHZ      100
`define TS_SETTLE_US    1
`define TS_SETTLE_CYC   (`TS_SETTLE_US * `TS_CLK_MHZ)
`define TS_TICK_PRESC   8
`define TS_TICK_MS      1
`define TS_TICK_DIVS    (`TS_TICK_MS * 1000 * `TS_CLK_MHZ / `TS_TICK_PRESC)
`define TS_CYCLE_MS     100
`define TS_SAMPLES      6
`define TS_SAMPLE_ST    8'hB4
// ----------------------------------------
// Arithmetic constants (mV, degrees)
// ----------------------------------------
`define TS_MV_LO        1800
`define TS_MV_MID       2700
`define TS_MV_HI        3300
`define TS_MV_SPAN      600
`define TS_DEG_SPAN     100
`define TS_ROOM_TENTHS  250
`define TS_SPAN_TENTHS  1000
`endif

/* File: hdl/sensor_control_reg_readout.v */
/*
  Calibrated temperature readout controller with an APB register slave.
  Assumes the converter answers each trigger with a one-cycle done strobe
  and its code on the same pclk; the switch is an asynchronous pin.
*/
`timescale 1ns/1ps
`include "sensor_control_reg_map.vh"
module tscrd_readout #(
  parameter TICK_DIVS = `TS_TICK_DIVS
) (
  // Clock and reset.
  input  wire        pclk,
  input  wire        presetn,
  // APB slave.
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Calibration switch pin.
  input  wire        calibrate_switch_input,
  // Sensor and converter control.
  output reg         amplifier_enable,
  output reg  [1:0]  amplifier_gain_select,
  output reg         adc_running,
  output reg         adc_single_scan,
  output reg         adc_sync_trigger_sel,
  output reg         adc_addition_en,
  output reg         adc_open_assist_en,
  output reg         adc_self_diag_en,
  output reg  [7:0]  adc_sample_states,
  output reg         adc_trigger,
  input  wire        adc_done,
  input  wire [9:0]  adc_data,
  // Display value in tenths of a degree.
  output reg  [15:0] disp_tenths,
  output reg         disp_dash,
  output reg         disp_update
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_INIT   = 3'd0;
  localparam ST_SETTLE = 3'd1;
  localparam ST_CWAIT  = 3'd2;
  localparam ST_IDLE   = 3'd3;
  localparam ST_TRIG   = 3'd4;
  localparam ST_CONV   = 3'd5;
  localparam ST_CALC   = 3'd6;

  reg [2:0]         state_r;
  reg [7:0]         settle_r;
  reg               sw_s1_r;
  reg               sw_s2_r;
  reg               sw_s3_r;
  reg               tick_run_r;
  reg [2:0]         presc_r;
  reg [16:0]        div_r;
  reg [6:0]         cyc_r;
  reg               burst_req_r;
  reg [2:0]         nsamp_r;
  reg [12:0]        sum_r;
  reg [9:0]         max_r;
  reg [9:0]         min_r;
  reg               cal_done_r;
  reg signed [31:0] room_r;
  reg signed [31:0] high_r;
  reg signed [31:0] slope_r;
  reg [15:0]        supply_mv_r;
  reg [15:0]        vref_mv_r;
  reg [9:0]         cal_lo_r;
  reg [9:0]         cal_mid_r;
  reg [9:0]         cal_hi_r;

  // ----------------------------------------
  // High reference reading
  // ----------------------------------------
  // Scaling by the reference in mV keeps everything in converter codes.
  function signed [31:0] high_ref;
    input [15:0] sup;
    input [15:0] vr;
    input [9:0]  c0;
    input [9:0]  c1;
    input [9:0]  c3;
    reg signed [31:0] h1;
    reg signed [31:0] h3;
    reg signed [31:0] vrs;
    begin
      vrs = (vr == 16'h0000) ? 32'sd1 : $signed({16'h0000, vr});
      h1 = (`TS_MV_MID * $signed({22'h00_0000, c1})) / vrs;
      h3 = (`TS_MV_HI * $signed({22'h00_0000, c3})) / vrs;
      if (sup < `TS_MV_MID) begin
        high_ref = (`TS_MV_LO * $signed({22'h00_0000, c0})) / vrs;
      end else begin
        high_ref = h1 + ((h3 - h1) * ($signed({16'h0000, sup}) - `TS_MV_MID))
                   / `TS_MV_SPAN;
      end
    end
  endfunction

  // ----------------------------------------
  // Burst arithmetic
  // ----------------------------------------
  // All values but temp_w, which is in tenths of a degree, are raw codes, never voltages, and divisions truncate.
  wire [12:0]        trim_w  = sum_r - {3'b000, max_r} - {3'b000, min_r};
  wire signed [31:0] avg_w   = $signed({21'h00_0000, trim_w[12:2]});
  wire signed [31:0] hi_w    = high_ref(supply_mv_r, vref_mv_r, cal_lo_r,
                                        cal_mid_r, cal_hi_r);
  wire signed [31:0] den_w   = high_r - room_r;
  wire signed [31:0] temp_w  = (den_w == 32'sd0) ? `TS_ROOM_TENTHS :
                               `TS_ROOM_TENTHS + (`TS_SPAN_TENTHS * (avg_w - room_r))
                               / den_w;

  // ----------------------------------------
  // Switch synchroniser and edge detect
  // ----------------------------------------
  // The first stage feeds only the second; the third keeps history.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_s1_r <= 1'b1;
      sw_s2_r <= 1'b1;
      sw_s3_r <= 1'b1;
    end else begin
      sw_s1_r <= calibrate_switch_input;
      sw_s2_r <= sw_s1_r;
      sw_s3_r <= sw_s2_r;
    end
  end

  wire sw_fall_w = sw_s3_r & ~sw_s2_r;

  // ----------------------------------------
  // Millisecond tick and cycle counter
  // ----------------------------------------
  // A burst request is raised once per 100 ticks and held until taken.
  wire presc_end_w = (presc_r == 3'd7);
  wire tick_w      = tick_run_r & presc_end_w & (div_r == TICK_DIVS - 1);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_r     <= 3'd0;
      div_r       <= 17'd0;
      cyc_r       <= 7'd0;
      burst_req_r <= 1'b0;
    end else begin
      if (tick_run_r) begin
        presc_r <= presc_r + 3'd1;
        if (presc_end_w) begin
          div_r <= tick_w ? 17'd0 : div_r + 17'd1;
        end
      end
      if (tick_w) begin
        if (cyc_r == `TS_CYCLE_MS - 1) begin
          cyc_r <= 7'd0;
        end else begin
          cyc_r <= cyc_r + 7'd1;
        end
      end
      if (tick_w && cyc_r == `TS_CYCLE_MS - 1) begin
        burst_req_r <= 1'b1;
      end else if (state_r == ST_IDLE) begin
        burst_req_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Main sequencer
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r              <= ST_INIT;
      settle_r             <= 8'd0;
      tick_run_r           <= 1'b0;
      nsamp_r              <= 3'd0;
      sum_r                <= 13'd0;
      max_r                <= 10'd0;
      min_r                <= 10'd0;
      cal_done_r           <= 1'b0;
      room_r               <= 32'sd0;
      high_r               <= 32'sd0;
      slope_r              <= 32'sd0;
      amplifier_enable     <= 1'b0;
      adc_running          <= 1'b0;
      adc_single_scan      <= 1'b0;
      adc_sync_trigger_sel <= 1'b0;
      adc_addition_en      <= 1'b0;
      adc_open_assist_en   <= 1'b0;
      adc_self_diag_en     <= 1'b0;
      adc_sample_states    <= 8'h00;
      adc_trigger          <= 1'b0;
      disp_tenths          <= 16'h0000;
      disp_dash            <= 1'b1;
      disp_update          <= 1'b0;
    end else begin
      adc_trigger <= 1'b0;
      disp_update <= 1'b0;
      case (state_r)
        // Converter set up and released from stop.
        ST_INIT: begin
          adc_single_scan      <= 1'b1;
          adc_sync_trigger_sel <= 1'b1;
          adc_sample_states    <= `TS_SAMPLE_ST;
          adc_addition_en      <= 1'b0;
          adc_open_assist_en   <= 1'b0;
          adc_self_diag_en     <= 1'b0;
          adc_running          <= 1'b1;
          settle_r             <= 8'd0;
          state_r              <= ST_SETTLE;
        end
        // The converter needs settling before the first start.
        ST_SETTLE: begin
          settle_r <= settle_r + 8'd1;
          if (settle_r == `TS_SETTLE_CYC - 1) begin
            state_r <= ST_CWAIT;
          end
        end
        ST_CWAIT: begin
          disp_dash <= 1'b1;
          if (sw_fall_w) begin
            tick_run_r <= 1'b1;
            state_r    <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (burst_req_r) begin
            amplifier_enable <= 1'b1;
            nsamp_r          <= 3'd0;
            sum_r            <= 13'd0;
            max_r            <= 10'h000;
            min_r            <= 10'h3FF;
            state_r          <= ST_TRIG;
          end
        end
        // Sensor trigger, one per conversion.
        ST_TRIG: begin
          adc_trigger <= 1'b1;
          state_r     <= ST_CONV;
        end
        ST_CONV: begin
          if (adc_done) begin
            sum_r   <= sum_r + {3'b000, adc_data};
            max_r   <= (adc_data > max_r) ? adc_data : max_r;
            min_r   <= (adc_data < min_r) ? adc_data : min_r;
            nsamp_r <= nsamp_r + 3'd1;
            if (nsamp_r == `TS_SAMPLES - 1) begin
              state_r <= ST_CALC;
            end else begin
              state_r <= ST_TRIG;
            end
          end
        end
        // Calibration on the first burst, temperature after that.
        ST_CALC: begin
          amplifier_enable <= 1'b0;
          state_r          <= ST_IDLE;
          if (!cal_done_r) begin
            room_r     <= avg_w;
            high_r     <= hi_w;
            slope_r    <= (hi_w - avg_w) / `TS_DEG_SPAN;
            cal_done_r <= 1'b1;
          end else begin
            disp_tenths <= temp_w[15:0];
            disp_dash   <= 1'b0;
            disp_update <= 1'b1;
          end
        end
        default: begin
          state_r <= ST_INIT;
        end
      endcase
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // Zero wait states; read data is captured in the setup cycle.
  function is_mapped;
    input [7:0] a;
    begin
      case (a)
        `TS_OFS_CTRL, `TS_OFS_SUPPLY, `TS_OFS_VREF, `TS_OFS_CAL_LO,
        `TS_OFS_CAL_MID, `TS_OFS_CAL_HI, `TS_OFS_STATUS, `TS_OFS_ROOM,
        `TS_OFS_SLOPE, `TS_OFS_TEMP, `TS_OFS_HIGH: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  wire wr_w = psel & penable & pwrite & is_mapped(paddr);

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~is_mapped(paddr);

  // Software writes steer gain, supply figures and calibration codes.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amplifier_gain_select <= `TS_RST_GAIN;
      supply_mv_r           <= `TS_RST_MV;
      vref_mv_r             <= `TS_RST_MV;
      cal_lo_r              <= 10'h000;
      cal_mid_r             <= 10'h000;
      cal_hi_r              <= 10'h000;
    end else if (wr_w) begin
      case (paddr)
        `TS_OFS_CTRL:    amplifier_gain_select <= pwdata[1:0];
        `TS_OFS_SUPPLY:  supply_mv_r <= pwdata[15:0];
        `TS_OFS_VREF:    vref_mv_r <= pwdata[15:0];
        `TS_OFS_CAL_LO:  cal_lo_r <= pwdata[`TS_CAL_W-1:0];
        `TS_OFS_CAL_MID: cal_mid_r <= pwdata[`TS_CAL_W-1:0];
        `TS_OFS_CAL_HI:  cal_hi_r <= pwdata[`TS_CAL_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Read data register; unmapped reads return zero.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        `TS_OFS_CTRL:    prdata <= {30'h0000_0000, amplifier_gain_select};
        `TS_OFS_SUPPLY:  prdata <= {16'h0000, supply_mv_r};
        `TS_OFS_VREF:    prdata <= {16'h0000, vref_mv_r};
        `TS_OFS_CAL_LO:  prdata <= {22'h00_0000, cal_lo_r};
        `TS_OFS_CAL_MID: prdata <= {22'h00_0000, cal_mid_r};
        `TS_OFS_CAL_HI:  prdata <= {22'h00_0000, cal_hi_r};
        `TS_OFS_STATUS:  prdata <= {25'h000_0000, tick_run_r, amplifier_enable,
                                    cal_done_r, 1'b0, state_r};
        `TS_OFS_ROOM:    prdata <= room_r;
        `TS_OFS_SLOPE:   prdata <= slope_r;
        `TS_OFS_TEMP:    prdata <= {{16{disp_tenths[15]}}, disp_tenths};
        `TS_OFS_HIGH:    prdata <= high_r;
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

/* File: verification/sensor_control_reg_adc_model.sv */
/* Behavioural converter that answers each trigger with one code.
   Assumes the readout pulses adc_trigger for one pclk cycle. */
`timescale 1ns/1ps
module tscrd_adc_model (
  // Clock and converter handshake.
  input  wire       pclk,
  input  wire       adc_trigger,
  output reg        adc_done,
  output reg  [9:0] adc_data
);
  reg     [9:0] codes [0:17];
  integer       k;
  // Codes per burst; latency alternates so both quick and slow answers occur.
  initial begin
    adc_done = 1'b0;
    adc_data = 10'h000;
    k = 0;
    codes = '{300, 310, 100, 900, 305, 305, 350, 360, 350, 340, 350, 350,
              200, 200, 1023, 0, 200, 200};
    forever begin
      @(posedge pclk);
      if (adc_trigger === 1'b1) begin
        repeat (k % 2 ? 20 : 3) @(posedge pclk);
        adc_done <= 1'b1;
        adc_data <= codes[k % 18];
        @(posedge pclk);
        adc_done <= 1'b0;
        // Stale data is inverted so a late sample shows up as a wrong code.
        adc_data <= ~codes[k % 18];
        k = k + 1;
      end
    end
  end
endmodule

/* File: verification/sensor_control_reg_readout_props.sv */
/* Port checker for the temperature readout.
   Assumes one pclk domain and an active-low asynchronous presetn. */
`timescale 1ns/1ps
module tscrd_readout_props #(
  parameter TICK_DIVS = 2
) (
  // Clock and reset.
  input wire       pclk,
  input wire       presetn,
  // Register bus.
  input wire       psel,
  input wire       penable,
  input wire [7:0] paddr,
  input wire       pready,
  input wire       pslverr,
  // Converter and sensor.
  input wire       amplifier_enable,
  input wire       adc_running,
  input wire       adc_single_scan,
  input wire       adc_sync_trigger_sel,
  input wire       adc_addition_en,
  input wire       adc_open_assist_en,
  input wire       adc_self_diag_en,
  input wire [7:0] adc_sample_states,
  input wire       adc_trigger,
  // Display.
  input wire       disp_dash,
  input wire       disp_update
);
  localparam int PERIOD = 800 * TICK_DIVS;
  reg [31:0] gap_r;
  reg        amp_q_r;
  reg [3:0]  ntrig_r;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Gap zero means no burst seen yet, so the first burst is not timed.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r   <= 32'h0000_0000;
      amp_q_r <= 1'b0;
      ntrig_r <= 4'h0;
    end else begin
      amp_q_r <= amplifier_enable;
      if (amplifier_enable && !amp_q_r) begin
        gap_r   <= 32'h0000_0001;
        ntrig_r <= 4'h0;
      end else begin
        if (gap_r != 0)
          gap_r <= gap_r + 1;
        if (adc_trigger)
          ntrig_r <= ntrig_r + 4'h1;
      end
    end
  end
  property p_period; amplifier_enable && !amp_q_r && gap_r != 0 |-> gap_r == PERIOD; endproperty
  a_period: assert property (p_period) else $error("burst period wrong");
  property p_six; $fell(amplifier_enable) |-> ntrig_r == 4'h6; endproperty
  a_six: assert property (p_six) else $error("burst not six conversions");
  property p_trig; adc_trigger |=> !adc_trigger; endproperty
  a_trig: assert property (p_trig) else $error("trigger pulse too long");
  property p_trig_amp; adc_trigger |-> amplifier_enable && adc_running; endproperty
  a_trig_amp: assert property (p_trig_amp) else $error("trigger outside burst");
  property p_cfg;
    adc_running |-> adc_single_scan && adc_sync_trigger_sel && adc_sample_states == 8'hB4;
  endproperty
  a_cfg: assert property (p_cfg) else $error("converter setup wrong");
  property p_off; !adc_addition_en && !adc_open_assist_en && !adc_self_diag_en; endproperty
  a_off: assert property (p_off) else $error("extra converter feature on");
  property p_dash; $fell(disp_dash) |-> disp_update; endproperty
  a_dash: assert property (p_dash) else $error("dash left without update");
  property p_upd; disp_update |=> !disp_update && !disp_dash; endproperty
  a_upd: assert property (p_upd) else $error("update pulse wrong");
  property p_err; psel && penable && paddr > 8'h28 |-> pslverr && pready; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
endmodule
bind tscrd_readout tscrd_readout_props #(.TICK_DIVS(TICK_DIVS)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .amplifier_enable(amplifier_enable),
  .adc_running(adc_running), .adc_single_scan(adc_single_scan),
  .adc_sync_trigger_sel(adc_sync_trigger_sel), .adc_addition_en(adc_addition_en),
  .adc_open_assist_en(adc_open_assist_en), .adc_self_diag_en(adc_self_diag_en),
  .adc_sample_states(adc_sample_states), .adc_trigger(adc_trigger),
  .disp_dash(disp_dash), .disp_update(disp_update));

/* File: verification/testbench.sv */
/* Self-checking bench for the temperature readout.
   Assumes the converter model holds three bursts of codes. */
`timescale 1ns/1ps
module testbench;
  reg         pclk, presetn, psel, penable, pwrite, sw, amp_seen, err;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire        pready, pslverr, amp, run, scan, sync, add, opn, diag, trig, done, dash, upd;
  wire [1:0]  gain;
  wire [7:0]  st;
  wire [9:0]  data;
  wire [15:0] tenths;
  integer     n_mismatch, tests_run;
  localparam integer ROOM = (300 + 310 + 305 + 305) / 4;
  localparam integer HIGH = 500;
  tscrd_readout #(.TICK_DIVS(2)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .calibrate_switch_input(sw), .amplifier_enable(amp), .amplifier_gain_select(gain),
    .adc_running(run), .adc_single_scan(scan), .adc_sync_trigger_sel(sync),
    .adc_addition_en(add), .adc_open_assist_en(opn), .adc_self_diag_en(diag),
    .adc_sample_states(st), .adc_trigger(trig), .adc_done(done), .adc_data(data),
    .disp_tenths(tenths), .disp_dash(dash), .disp_update(upd));
  tscrd_adc_model u_adc (.pclk(pclk), .adc_trigger(trig), .adc_done(done), .adc_data(data));
  // Expected tenths from a burst average; integer division truncates toward zero.
  function integer t10(input integer a);
    t10 = 250 + (1000 * (a - ROOM)) / (HIGH - ROOM);
  endfunction
  task report_and_stop;
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    tests_run = tests_run + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One transfer, then an idle cycle so no signal is driven twice in a step.
  task apb(input w, input [7:0] a, input [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wait_sig(input sel, input v);
    integer n;
    n = 0;
    while ((sel ? upd : amp) !== v && n < 4000) begin
      @(posedge pclk);
      n = n + 1;
    end
    // A wait that runs out of time must count as a mismatch, not pass silently.
    chk(sel ? upd : amp, v);
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // A run lasts about 9000 cycles; the limit leaves ample room.
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch = n_mismatch + 1;
    report_and_stop;
  end
  always @(posedge pclk) if (amp === 1'b1) amp_seen <= 1'b1;
  initial begin
    {presetn, psel, penable, pwrite, amp_seen, paddr, pwdata} = 0;
    sw = 1'b1;
    n_mismatch = 0;
    tests_run = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (120) @(posedge pclk);
    chk({dash, run, scan, sync, st}, 12'hF_B4);
    chk({add, opn, diag, gain}, 5'b00001);
    apb(0, 8'h18, 0); chk(rd[2:0], 3'd2);
    apb(0, 8'h04, 0); chk(rd, 32'h0000_0CE4);
    apb(0, 8'h40, 0); chk({err, rd[30:0]}, 32'h8000_0000);
    apb(1, 8'h00, 0); chk(gain, 2'b00);
    apb(1, 8'h00, 1);
    apb(1, 8'h0C, 32'hFFFF_F3FF); apb(0, 8'h0C, 0); chk(rd, 32'h0000_03FF);
    apb(1, 8'h10, 330);
    apb(1, 8'h14, HIGH);
    repeat (1700) @(posedge pclk);
    chk(amp_seen, 1'b0);
    sw <= 1'b0;
    wait_sig(0, 1);
    wait_sig(0, 0);
    repeat (3) @(posedge pclk);
    apb(0, 8'h1C, 0); chk(rd, ROOM);
    apb(0, 8'h28, 0); chk(rd, HIGH);
    apb(0, 8'h20, 0); chk(rd, (HIGH - ROOM) / 100);
    apb(0, 8'h18, 0); chk({rd[4], dash}, 2'b11);
    wait_sig(1, 1); chk(tenths, t10(350));
    @(posedge pclk); chk(dash, 1'b0);
    wait_sig(1, 1); chk(tenths, t10(200) & 32'h0000_FFFF);
    @(posedge pclk);
    apb(0, 8'h24, 0); chk(rd, t10(200));
    // Second reset mid-run, then a calibration on the low-supply formula.
    presetn <= 1'b0;
    sw <= 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1, 8'h04, 2000);
    apb(1, 8'h08, 2000);
    apb(1, 8'h0C, 600);
    repeat (120) @(posedge pclk);
    chk({dash, upd, amp}, 3'b100);
    apb(0, 8'h18, 0); chk(rd[6:0], 7'h02);
    sw <= 1'b0;
    wait_sig(0, 1);
    wait_sig(0, 0);
    repeat (3) @(posedge pclk);
    apb(0, 8'h1C, 0); chk(rd, ROOM);
    apb(0, 8'h28, 0); chk(rd, 1800 * 600 / 2000);
    report_and_stop;
  end
endmodule
